/* core/flow_buffer_device.sv */
// Flow buffer device: port caches, routing sequencer and external memory control
`timescale 1ns/1ps
module flow_buffer_device #(
  parameter int IN_W        = flow_pkg::PORT_W36,
  parameter int OUT_W       = flow_pkg::PORT_W36,
  parameter int PART_W      = flow_pkg::PART_W16,
  parameter int MEM_W       = flow_pkg::BUS_W64,
  parameter int DENSITY_MB  = flow_pkg::DENS_256_MBIT,
  parameter int MEM_CLK_MHZ = flow_pkg::MEM_CLK_166_MHZ,
  parameter int ADDR_W      = flow_pkg::ADDR_W_16MX16,
  parameter int COL_W       = 9,
  parameter int CAP_WORDS   = 16384,
  parameter int REFRESH_CYC = 1560,
  parameter int CAS_LAT     = 3,
  parameter int CACHE_AW    = 4
) (
  flow_link_if.device                      link,
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst_n,
  output logic                             o_mem_ck,
  output logic                             o_mem_ck_n,
  output logic [flow_pkg::MEM_ADDR_W-1:0]  o_mem_addr,
  output logic [flow_pkg::MEM_BA_W-1:0]    o_mem_ba,
  output logic                             o_mem_ras_n,
  output logic                             o_mem_cas_n,
  output logic                             o_mem_we_n,
  input  wire logic [flow_pkg::MEM_DQ_W-1:0]  i_mem_dq,
  output logic [flow_pkg::MEM_DQ_W-1:0]    o_mem_dq,
  output logic                             o_mem_dq_oe,
  input  wire logic [flow_pkg::MEM_DQS_W-1:0] i_mem_dqs,
  output logic [flow_pkg::MEM_DQS_W-1:0]   o_mem_dqs,
  output logic                             o_mem_dqs_oe
);
  localparam int W     = flow_pkg::PORT_W;
  localparam int BEATS = (W + MEM_W - 1) / MEM_W;
  localparam int CNT_W = $clog2(CAP_WORDS + 1);
  localparam int LIN_W = ADDR_W + COL_W + flow_pkg::MEM_BA_W;
  // Timing by part width, counted in controller cycles
  localparam int RFC_C  = (PART_W == flow_pkg::PART_W16) ? flow_pkg::TRFC16_CYC : flow_pkg::TRFC32_CYC;
  // Core reset stretch, so the port clock runs while the port side is held
  localparam int PRST_HOLD = 24;

  // Core reset held past the system reset; the port clock is stopped in reset
  logic [7:0] hold_q;
  logic       core_rst_n;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      hold_q <= '0;
    end else if (hold_q != 8'(PRST_HOLD)) begin
      hold_q <= hold_q + 8'h01;
    end
  end
  assign core_rst_n = (hold_q == 8'(PRST_HOLD));
  localparam int RCDW_C = (PART_W == flow_pkg::PART_W16) ? flow_pkg::TRCD16_CYC : flow_pkg::TRCDWR32_CYC;
  localparam int RCDR_C = (PART_W == flow_pkg::PART_W16) ? flow_pkg::TRCD16_CYC : flow_pkg::TRCDRD32_CYC;
  localparam int RP_C   = (PART_W == flow_pkg::PART_W16) ? flow_pkg::TRP16_CYC : flow_pkg::TRP32_CYC;

  // Port clock domain reset, released two port edges after the core reset
  logic prst_s1_q;
  logic prst_q;
  always_ff @(posedge link.port_clk) begin
    prst_s1_q <= core_rst_n;
    prst_q    <= prst_s1_q;
  end

  // Port strobes; either one high blocks the transfer
  wire write_take = ~link.write_enable_n & ~link.write_select_n;
  wire read_take  = ~link.read_enable_n & ~link.read_select_n;
  wire [W-1:0] in_word = {{(W-IN_W){1'b0}}, link.wdata[IN_W-1:0]};

  logic         in_full;
  logic [W-1:0] in_head;
  logic         in_empty;
  logic         in_pop;
  logic         out_full;
  logic         out_push;
  logic [W-1:0] out_word;
  logic [W-1:0] out_head;
  logic         out_empty;

  // Staging cache from the write port into the sequencer
  staging_cache #(.W(W), .AW(CACHE_AW)) u_in_cache (
    .i_wclk  (link.port_clk),
    .i_wrst_n(prst_q),
    .i_push  (write_take),
    .i_wdata (in_word),
    .o_full  (in_full),
    .i_rclk  (i_mclk),
    .i_rrst_n(core_rst_n),
    .i_pop   (in_pop),
    .o_rdata (in_head),
    .o_empty (in_empty)
  );

  // Output cache from the sequencer toward the read port
  staging_cache #(.W(W), .AW(CACHE_AW)) u_out_cache (
    .i_wclk  (i_mclk),
    .i_wrst_n(core_rst_n),
    .i_push  (out_push),
    .i_wdata (out_word),
    .o_full  (out_full),
    .i_rclk  (link.port_clk),
    .i_rrst_n(prst_q),
    .i_pop   (read_take),
    .o_rdata (out_head),
    .o_empty (out_empty)
  );

  // Output word register on the read port
  logic [W-1:0] rdata_q;
  logic         rvalid_q;
  always_ff @(posedge link.port_clk) begin
    if (!prst_q) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else if (read_take && !out_empty) begin
      rdata_q  <= {{(W-OUT_W){1'b0}}, out_head[OUT_W-1:0]};
      rvalid_q <= 1'b1;
    end else begin
      rvalid_q <= 1'b0;
    end
  end
  assign link.rdata       = rdata_q;
  assign link.rdata_valid = rvalid_q;

  // Sequencer registers
  flow_pkg::mem_state_type state_q;
  logic [flow_pkg::WAIT_W-1:0] wait_q;
  logic [15:0]                 refresh_q;
  logic                        refresh_due_q;
  logic [CNT_W-1:0]            count_q;
  logic [CNT_W-1:0]            wr_idx_q;
  logic [CNT_W-1:0]            rd_idx_q;
  logic                        is_read_q;
  logic [7:0]                  beat_q;
  logic [BEATS*MEM_W-1:0]      word_q;
  logic [2:0]                  cmd_q;
  logic [flow_pkg::MEM_ADDR_W-1:0] addr_q;
  logic [flow_pkg::MEM_BA_W-1:0]   ba_q;
  logic [MEM_W-1:0]            dq_q;
  logic                        dq_oe_q;
  logic                        ck_q;

  // Routing decisions: memory path only keeps order once memory holds data
  wire mem_empty  = (count_q == '0);
  wire mem_full   = (count_q == CNT_W'(CAP_WORDS));
  wire go_bypass  = ~in_empty & mem_empty & ~out_full;
  wire go_store   = ~in_empty & (~mem_empty | out_full) & ~mem_full;
  wire go_fetch   = ~mem_empty & ~out_full;
  wire idle       = (state_q == flow_pkg::S_IDLE);
  wire last_beat  = (beat_q == 8'(BEATS - 1));
  wire [CNT_W-1:0] cur_idx = is_read_q ? rd_idx_q : wr_idx_q;
  wire [LIN_W-1:0] lin = LIN_W'(cur_idx) * LIN_W'(BEATS);
  assign in_pop   = (idle & ~refresh_due_q & go_bypass & ~go_store) | (state_q == flow_pkg::S_CMD & ~is_read_q);
  assign out_push = (idle & ~refresh_due_q & go_bypass & ~go_store) | (state_q == flow_pkg::S_BEAT & is_read_q & last_beat);
  // Read word with the beat now on the bus merged in, so the push carries it
  logic [BEATS*MEM_W-1:0] word_cap;
  always_comb begin
    word_cap = word_q;
    word_cap[beat_q*MEM_W +: MEM_W] = i_mem_dq[MEM_W-1:0];
  end
  assign out_word = (state_q == flow_pkg::S_BEAT) ? word_cap[W-1:0] : in_head;

  // Refresh interval timer
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      refresh_q     <= '0;
      refresh_due_q <= 1'b0;
    end else if (refresh_q == 16'(REFRESH_CYC - 1)) begin
      refresh_q     <= '0;
      refresh_due_q <= 1'b1;
    end else begin
      refresh_q     <= refresh_q + 16'h0001;
      if (idle && cmd_q == flow_pkg::CMD_NOP && refresh_due_q) begin
        refresh_due_q <= 1'b0;
      end
    end
  end

  // Memory sequencer; auto precharge closes each row after the access
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_q   <= flow_pkg::S_IDLE;
      wait_q    <= '0;
      count_q   <= '0;
      wr_idx_q  <= '0;
      rd_idx_q  <= '0;
      is_read_q <= 1'b0;
      beat_q    <= '0;
      word_q    <= '0;
      cmd_q     <= flow_pkg::CMD_NOP;
      addr_q    <= '0;
      ba_q      <= '0;
      dq_q      <= '0;
      dq_oe_q   <= 1'b0;
      ck_q      <= 1'b0;
    end else begin
      ck_q  <= ~ck_q;
      cmd_q <= flow_pkg::CMD_NOP;
      case (state_q)
        flow_pkg::S_IDLE: begin
          dq_oe_q <= 1'b0;
          if (refresh_due_q) begin
            cmd_q   <= flow_pkg::CMD_REF;
            wait_q  <= flow_pkg::WAIT_W'(RFC_C);
            state_q <= flow_pkg::S_REC;
          end else if (go_store || go_fetch) begin
            is_read_q <= ~go_store;
            cmd_q     <= flow_pkg::CMD_ACT;
            ba_q      <= lin[LIN_W-1 -: flow_pkg::MEM_BA_W];
            addr_q    <= flow_pkg::MEM_ADDR_W'(lin[COL_W +: ADDR_W]);
            wait_q    <= flow_pkg::WAIT_W'(go_store ? RCDW_C : RCDR_C);
            state_q   <= flow_pkg::S_RCD;
          end
        end
        flow_pkg::S_RCD: begin
          wait_q <= wait_q - 1'b1;
          if (wait_q == flow_pkg::WAIT_W'(1)) begin
            state_q <= flow_pkg::S_CMD;
          end
        end
        flow_pkg::S_CMD: begin
          cmd_q  <= is_read_q ? flow_pkg::CMD_RD : flow_pkg::CMD_WR;
          addr_q <= flow_pkg::MEM_ADDR_W'(lin[COL_W-1:0]) | (flow_pkg::MEM_ADDR_W'(1) << flow_pkg::AUTO_PRE_BIT);
          beat_q <= '0;
          word_q <= (BEATS*MEM_W)'(in_head);
          wait_q <= flow_pkg::WAIT_W'(CAS_LAT);
          state_q <= is_read_q ? flow_pkg::S_CASW : flow_pkg::S_BEAT;
        end
        flow_pkg::S_CASW: begin
          wait_q <= wait_q - 1'b1;
          if (wait_q == flow_pkg::WAIT_W'(1)) begin
            state_q <= flow_pkg::S_BEAT;
          end
        end
        flow_pkg::S_BEAT: begin
          beat_q <= beat_q + 8'h01;
          if (is_read_q) begin
            word_q[beat_q*MEM_W +: MEM_W] <= i_mem_dq[MEM_W-1:0];
          end else begin
            dq_q    <= word_q[beat_q*MEM_W +: MEM_W];
            dq_oe_q <= 1'b1;
          end
          if (last_beat) begin
            wait_q  <= flow_pkg::WAIT_W'(RP_C);
            state_q <= flow_pkg::S_REC;
            if (is_read_q) begin
              count_q  <= count_q - 1'b1;
              rd_idx_q <= (rd_idx_q == CNT_W'(CAP_WORDS - 1)) ? '0 : rd_idx_q + 1'b1;
            end else begin
              count_q  <= count_q + 1'b1;
              wr_idx_q <= (wr_idx_q == CNT_W'(CAP_WORDS - 1)) ? '0 : wr_idx_q + 1'b1;
            end
          end
        end
        flow_pkg::S_REC: begin
          dq_oe_q <= 1'b0;
          wait_q  <= wait_q - 1'b1;
          if (wait_q <= flow_pkg::WAIT_W'(1)) begin
            state_q <= flow_pkg::S_IDLE;
          end
        end
        default: begin
          state_q <= flow_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Memory pins; enable, select and mask are strapped on the board
  assign o_mem_ck     = ck_q;
  assign o_mem_ck_n   = ~ck_q;
  assign {o_mem_ras_n, o_mem_cas_n, o_mem_we_n} = cmd_q;
  assign o_mem_addr   = addr_q;
  assign o_mem_ba     = ba_q;
  assign o_mem_dq     = flow_pkg::MEM_DQ_W'(dq_q);
  assign o_mem_dq_oe  = dq_oe_q;
  assign o_mem_dqs    = {flow_pkg::MEM_DQS_W{ck_q & dq_oe_q}};
  assign o_mem_dqs_oe = dq_oe_q;
endmodule : flow_buffer_device

/* core/flow_pkg.sv */
// Shared constants and types for the flow buffer device and its host
package flow_pkg;
  // Port word and memory pin widths
  localparam int PORT_W     = 36;
  localparam int MEM_DQ_W   = 64;
  localparam int MEM_DQS_W  = 8;
  localparam int MEM_ADDR_W = 13;
  localparam int MEM_BA_W   = 2;
  localparam int AUTO_PRE_BIT = 10;

  // Supported port widths, memory widths, densities and address widths
  localparam int PORT_W9  = 9;
  localparam int PORT_W18 = 18;
  localparam int PORT_W36 = 36;
  localparam int PART_W16 = 16;
  localparam int PART_W32 = 32;
  localparam int BUS_W16  = 16;
  localparam int BUS_W32  = 32;
  localparam int BUS_W36  = 36;
  localparam int BUS_W64  = 64;
  localparam int DENS_128_MBIT = 128;
  localparam int DENS_256_MBIT = 256;
  localparam int ADDR_W_8MX16  = 12;
  localparam int ADDR_W_16MX16 = 13;
  localparam int TOTAL_MIN_MBIT  = 128;
  localparam int TOTAL_MAX_MBIT  = 1024;
  localparam int TOTAL_3X256_MBIT  = 768;
  localparam int USABLE_3X256_MBIT = 567;
  localparam int MEM_CLK_133_MHZ = 133;
  localparam int MEM_CLK_166_MHZ = 166;

  // Controller clock and memory timing minima
  localparam int MCLK_PS     = 5000;
  localparam int TRFC16_NS   = 75;
  localparam int TRFC32_NS   = 63;
  localparam int TRCD16_NS   = 20;
  localparam int TRCDWR32_NS = 9;
  localparam int TRCDRD32_NS = 18;
  localparam int TRP16_NS    = 20;
  localparam int TRP32_NS    = 18;
  localparam int TRFC16_CYC   = (TRFC16_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
  localparam int TRFC32_CYC   = (TRFC32_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
  localparam int TRCD16_CYC   = (TRCD16_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
  localparam int TRCDWR32_CYC = (TRCDWR32_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
  localparam int TRCDRD32_CYC = (TRCDRD32_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
  localparam int TRP16_CYC    = (TRP16_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
  localparam int TRP32_CYC    = (TRP32_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
  localparam int WAIT_W = 8;

  // Memory commands as {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_REF = 3'h1;

  // Memory sequencer states, Gray along the read path from S_IDLE up to S_REC
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_RCD  = 3'h1,
    S_CMD  = 3'h3,
    S_CASW = 3'h2,
    S_BEAT = 3'h6,
    S_REC  = 3'h7
  } mem_state_type;
endpackage : flow_pkg

/* core/flow_link_if.sv */
// Write and read port link between host logic and the flow buffer device
`timescale 1ns/1ps
interface flow_link_if;
  logic                       port_clk;
  logic                       write_enable_n;
  logic                       write_select_n;
  logic [flow_pkg::PORT_W-1:0] wdata;
  logic                       read_enable_n;
  logic                       read_select_n;
  logic [flow_pkg::PORT_W-1:0] rdata;
  logic                       rdata_valid;

  modport device (
    input  port_clk, write_enable_n, write_select_n, wdata, read_enable_n, read_select_n,
    output rdata, rdata_valid
  );
  modport host (
    output port_clk, write_enable_n, write_select_n, wdata, read_enable_n, read_select_n,
    input  rdata, rdata_valid
  );
endinterface : flow_link_if

/* core/staging_cache.sv */
// Dual clock word cache with Gray coded pointers
`timescale 1ns/1ps
module staging_cache #(
  parameter int W  = 36,
  parameter int AW = 4
) (
  input  wire logic         i_wclk,
  input  wire logic         i_wrst_n,
  input  wire logic         i_push,
  input  wire logic [W-1:0] i_wdata,
  output logic              o_full,
  input  wire logic         i_rclk,
  input  wire logic         i_rrst_n,
  input  wire logic         i_pop,
  output logic [W-1:0]      o_rdata,
  output logic              o_empty
);
  logic [W-1:0] mem_q [0:(1<<AW)-1];
  logic [AW:0]  wbin_q;
  logic [AW:0]  wgray_q;
  logic [AW:0]  rbin_q;
  logic [AW:0]  rgray_q;
  logic [AW:0]  rg_s1_q;
  logic [AW:0]  rg_s2_q;
  logic [AW:0]  wg_s1_q;
  logic [AW:0]  wg_s2_q;

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  // Pointer steps and flags
  wire         push_ok = i_push & ~o_full;
  wire         pop_ok  = i_pop & ~o_empty;
  wire [AW:0]  wbin_d  = wbin_q + {{AW{1'b0}}, push_ok};
  wire [AW:0]  rbin_d  = rbin_q + {{AW{1'b0}}, pop_ok};
  assign o_full  = (wgray_q == {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]});
  assign o_empty = (rgray_q == wg_s2_q);
  assign o_rdata = mem_q[rbin_q[AW-1:0]];

  // Write side, read pointer synchronised in
  always_ff @(posedge i_wclk) begin
    if (push_ok) begin
      mem_q[wbin_q[AW-1:0]] <= i_wdata;
    end
    if (!i_wrst_n) begin
      wbin_q  <= '0;
      wgray_q <= '0;
      rg_s1_q <= '0;
      rg_s2_q <= '0;
    end else begin
      wbin_q  <= wbin_d;
      wgray_q <= bin2gray(wbin_d);
      rg_s1_q <= rgray_q;
      rg_s2_q <= rg_s1_q;
    end
  end

  // Read side, write pointer synchronised in
  always_ff @(posedge i_rclk) begin
    if (!i_rrst_n) begin
      rbin_q  <= '0;
      rgray_q <= '0;
      wg_s1_q <= '0;
      wg_s2_q <= '0;
    end else begin
      rbin_q  <= rbin_d;
      rgray_q <= bin2gray(rbin_d);
      wg_s1_q <= wgray_q;
      wg_s2_q <= wg_s1_q;
    end
  end
endmodule : staging_cache

/* core/flow_host.sv */
// Host logic end: makes the port clock and drives the write and read ports
`timescale 1ns/1ps
module flow_host #(
  parameter int HALF_DIV = 2
) (
  flow_link_if.host                    link,
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_wr_valid,
  input  wire logic [flow_pkg::PORT_W-1:0] i_wr_data,
  output logic                         o_wr_ready,
  input  wire logic                    i_rd_req,
  output logic                         o_rd_req_taken,
  output logic                         o_rd_valid,
  output logic [flow_pkg::PORT_W-1:0]  o_rd_data
);
  logic [7:0]                 div_q;
  logic                       clk_q;
  logic                       wen_n_q;
  logic                       ren_n_q;
  logic [flow_pkg::PORT_W-1:0] wdata_q;
  logic                       rvalid_q;
  logic [flow_pkg::PORT_W-1:0] rdata_q;

  // Divider ticks; strobes change on the falling half, data sampled before rising
  wire tick      = (div_q == 8'(HALF_DIV - 1));
  wire fall_tick = tick & clk_q;
  wire rise_tick = tick & ~clk_q;
  assign o_wr_ready     = fall_tick & i_rst_n;
  assign o_rd_req_taken = fall_tick & i_rst_n & i_rd_req;

  // Free running port clock and port strobes
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      div_q    <= '0;
      clk_q    <= 1'b0;
      wen_n_q  <= 1'b1;
      ren_n_q  <= 1'b1;
      wdata_q  <= '0;
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
    end else begin
      div_q    <= tick ? 8'h00 : div_q + 8'h01;
      clk_q    <= tick ? ~clk_q : clk_q;
      rvalid_q <= 1'b0;
      if (fall_tick) begin
        wen_n_q <= ~i_wr_valid;
        wdata_q <= i_wr_data;
        ren_n_q <= ~i_rd_req;
      end
      if (rise_tick) begin
        rvalid_q <= link.rdata_valid;
        rdata_q  <= link.rdata;
      end
    end
  end

  assign link.port_clk       = clk_q;
  assign link.write_enable_n = wen_n_q;
  assign link.write_select_n = wen_n_q;
  assign link.wdata          = wdata_q;
  assign link.read_enable_n  = ren_n_q;
  assign link.read_select_n  = ren_n_q;
  assign o_rd_valid          = rvalid_q;
  assign o_rd_data           = rdata_q;
endmodule : flow_host

/* sim/flow_link_properties.sv */
// Assertions on the port link and the memory command pins of the flow buffer
`timescale 1ns/1ps
module flow_link_properties #(
  parameter int PART_W = 16
) (
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  input wire logic        port_clk,
  input wire logic        write_enable_n,
  input wire logic        write_select_n,
  input wire logic        read_enable_n,
  input wire logic        read_select_n,
  input wire logic [35:0] rdata,
  input wire logic        rdata_valid,
  input wire logic [12:0] o_mem_addr,
  input wire logic        o_mem_ras_n,
  input wire logic        o_mem_cas_n,
  input wire logic        o_mem_we_n,
  input wire logic        o_mem_dq_oe
);
  localparam int T_RFC = (PART_W == 16) ? flow_pkg::TRFC16_CYC : flow_pkg::TRFC32_CYC;
  localparam int T_WR  = (PART_W == 16) ? flow_pkg::TRCD16_CYC : flow_pkg::TRCDWR32_CYC;
  localparam int T_RD  = (PART_W == 16) ? flow_pkg::TRCD16_CYC : flow_pkg::TRCDRD32_CYC;
  logic [2:0] cmd;
  logic       acc;
  logic       rd_take;
  logic       port_ok;
  logic [2:0] last_q;
  logic [2:0] last_d;
  logic [7:0] gap_q;
  logic [7:0] gap_d;
  logic [5:0] up_q;
  logic [5:0] up_d;

  // Command decode, cycles since last command, settle time after reset
  assign cmd     = {o_mem_ras_n, o_mem_cas_n, o_mem_we_n};
  assign acc     = (cmd == flow_pkg::CMD_RD) || (cmd == flow_pkg::CMD_WR);
  assign rd_take = !read_enable_n && !read_select_n;
  assign last_d  = (cmd != flow_pkg::CMD_NOP) ? cmd : last_q;
  assign gap_d   = (cmd != flow_pkg::CMD_NOP) ? 8'h01 : gap_q + {7'h00, gap_q != 8'hFF};
  assign up_d    = up_q + {5'h00, up_q != 6'h3F};
  assign port_ok = (up_q == 6'h3F);

  // Helper registers
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      last_q <= flow_pkg::CMD_NOP;
      gap_q  <= 8'h00;
      up_q   <= 6'h00;
    end else begin
      last_q <= last_d;
      gap_q  <= gap_d;
      up_q   <= up_d;
    end
  end

  property p_cmd_single;
    @(posedge i_mclk) disable iff (!i_rst_n) cmd != flow_pkg::CMD_NOP |=> cmd == flow_pkg::CMD_NOP;
  endproperty
  a_cmd_single: assert property (p_cmd_single) else $error("memory command held too long");
  property p_refresh_gap;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (cmd != flow_pkg::CMD_NOP && last_q == flow_pkg::CMD_REF) |-> gap_q >= T_RFC;
  endproperty
  a_refresh_gap: assert property (p_refresh_gap) else $error("command too soon after refresh");
  property p_act_gap;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (acc && last_q == flow_pkg::CMD_ACT) |-> gap_q >= ((cmd == flow_pkg::CMD_WR) ? T_WR : T_RD);
  endproperty
  a_act_gap: assert property (p_act_gap) else $error("access too soon after activate");
  property p_act_access;
    @(posedge i_mclk) disable iff (!i_rst_n) cmd == flow_pkg::CMD_ACT |-> ##[1:16] acc;
  endproperty
  a_act_access: assert property (p_act_access) else $error("activate not followed by access");
  property p_auto_pre;
    @(posedge i_mclk) disable iff (!i_rst_n) acc |-> o_mem_addr[flow_pkg::AUTO_PRE_BIT];
  endproperty
  a_auto_pre: assert property (p_auto_pre) else $error("access without auto precharge");
  property p_strobes_paired;
    @(posedge i_mclk) disable iff (!i_rst_n)
      write_enable_n == write_select_n && read_enable_n == read_select_n;
  endproperty
  a_strobes_paired: assert property (p_strobes_paired) else $error("port strobes differ");
  property p_valid_cause;
    @(posedge port_clk) disable iff (!i_rst_n || !port_ok) rdata_valid |-> $past(rd_take);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("word without read strobe");
  property p_idle_quiet;
    @(posedge port_clk) disable iff (!i_rst_n || !port_ok) !rd_take |=> !rdata_valid;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("word with strobe high");
  property p_rdata_hold;
    @(posedge port_clk) disable iff (!i_rst_n || !port_ok) !rdata_valid |-> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("output word moved while idle");

  c_refresh: cover property (@(posedge i_mclk) cmd == flow_pkg::CMD_REF);
  c_mem_write: cover property (@(posedge i_mclk) $rose(o_mem_dq_oe));
  c_read_word: cover property (@(posedge port_clk) rdata_valid);
endmodule : flow_link_properties

/* sim/sequential_fifo_ddr_ports_tb_top.sv */
// Testbench: host end and flow buffer device joined by the port link
`timescale 1ns/1ps
module sequential_fifo_ddr_ports_tb_top;
  logic        i_mclk;
  logic        i_rst_n;
  logic        wr_valid;
  logic [35:0] wr_data;
  logic        wr_ready;
  logic        rd_req;
  logic        rd_valid;
  logic [35:0] rd_data;
  logic [12:0] mem_addr;
  logic [1:0]  mem_ba;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic        dq_oe;
  logic [2:0]  mcmd;
  logic [63:0] dq_out;
  logic [63:0] dq_in;
  logic [63:0] rd_word;
  logic [3:0]  rd_age;
  logic [23:0] key;
  logic [12:0] row_q [4];
  logic [63:0] mem [logic [23:0]];
  logic [35:0] exp_q [$];
  int          n_fail;
  int          n_tests;
  int          n_rcv;

  flow_link_if link ();
  flow_host #(.HALF_DIV(2)) u_flow_host (.link(link), .i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_wr_valid(wr_valid), .i_wr_data(wr_data), .o_wr_ready(wr_ready), .i_rd_req(rd_req),
    .o_rd_req_taken(), .o_rd_valid(rd_valid), .o_rd_data(rd_data));
  flow_buffer_device #(.REFRESH_CYC(100)) u_flow_buffer_device (.link(link), .i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .o_mem_ck(), .o_mem_ck_n(), .o_mem_addr(mem_addr), .o_mem_ba(mem_ba),
    .o_mem_ras_n(ras_n), .o_mem_cas_n(cas_n), .o_mem_we_n(we_n), .i_mem_dq(dq_in), .o_mem_dq(dq_out),
    .o_mem_dq_oe(dq_oe), .i_mem_dqs(8'h00), .o_mem_dqs(), .o_mem_dqs_oe());
  flow_link_properties #(.PART_W(flow_pkg::PART_W16)) u_flow_link_properties (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .port_clk(link.port_clk), .write_enable_n(link.write_enable_n),
    .write_select_n(link.write_select_n), .read_enable_n(link.read_enable_n),
    .read_select_n(link.read_select_n), .rdata(link.rdata), .rdata_valid(link.rdata_valid),
    .o_mem_addr(mem_addr), .o_mem_ras_n(ras_n), .o_mem_cas_n(cas_n), .o_mem_we_n(we_n), .o_mem_dq_oe(dq_oe));

  assign mcmd = {ras_n, cas_n, we_n};
  // Main clock
  always #2.5 i_mclk = ~i_mclk;

  // Memory model: open rows, word store, read window, bus toggles when idle
  // One model stands for all parts: same density and grade
  always @(posedge i_mclk) begin
    if (mcmd == flow_pkg::CMD_ACT) row_q[mem_ba] <= mem_addr;
    if (mcmd == flow_pkg::CMD_WR || mcmd == flow_pkg::CMD_RD) key = {mem_ba, row_q[mem_ba], mem_addr[8:0]};
    if (dq_oe === 1'b1) mem[key] = dq_out;
    if (mcmd == flow_pkg::CMD_RD) rd_word = mem.exists(key) ? mem[key] : 64'h0;
    dq_in <= (rd_age >= 4'h1 && rd_age <= 4'h6) ? rd_word : ~dq_in;
    if (mcmd == flow_pkg::CMD_RD) rd_age <= 4'h1;
    else if (rd_age != 4'h0 && rd_age != 4'hF) rd_age <= rd_age + 4'h1;
  end

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One word through the host write handshake
  task automatic put(input logic [35:0] d);
    int i;
    i = 0;
    @(posedge i_mclk);
    wr_data  <= d;
    wr_valid <= 1'b1;
    exp_q.push_back(d);
    do begin @(negedge i_mclk); i++; end while (wr_ready !== 1'b1 && i < 64);
    @(posedge i_mclk);
    wr_valid <= 1'b0;
  endtask : put

  task automatic send(input int n, input int gap, input logic [35:0] base);
    for (int k = 0; k < n; k++) begin
      put(base + 36'(k));
      repeat (gap) @(posedge i_mclk);
    end
  endtask : send

  // Hold the read request until the total word count is reached
  task automatic drain(input int n);
    int t;
    t = 0;
    @(posedge i_mclk);
    rd_req <= 1'b1;
    while (n_rcv < n && t < 4000) begin @(posedge i_mclk); t++; end
    rd_req <= 1'b0;
  endtask : drain

  task automatic close_out();
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // Compare every delivered word against write order
  always @(negedge i_mclk) begin
    if (rd_valid === 1'b1) begin
      n_rcv++;
      check(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 36'h0);
    end
  end

  // Main sequence
  initial begin
    i_mclk = 1'b0; i_rst_n = 1'b0; wr_valid = 1'b0; wr_data = 36'h0; rd_req = 1'b0;
    dq_in = 64'h0; rd_age = 4'h0; key = 24'h0; rd_word = 64'h0; n_fail = 0; n_tests = 0; n_rcv = 0;
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (40) @(posedge i_mclk);
    check({35'h0, rd_valid}, 36'h0);
    send(8, 0, 36'hA_0000_0000);
    repeat (60) @(posedge i_mclk);
    check(36'(n_rcv), 36'h0);
    drain(8);
    send(40, 32, 36'h5_0000_0100);
    repeat (400) @(posedge i_mclk);
    drain(48);
    fork
      send(20, 32, 36'hC_0000_0200);
      drain(68);
    join
    check(36'(n_rcv), 36'h44);
    close_out();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_fail++;
    close_out();
  end
endmodule : sequential_fifo_ddr_ports_tb_top
